// >>> logic/conv_seq_pkg.sv
// Purpose: shared constants and types for the converter sequencer pair
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: control byte layout, result addressing, host register map
package conv_seq_pkg;
    // -------------------------------------------------
    // control byte fields
    // -------------------------------------------------
    localparam int ctrl_width = 8;
    localparam int pwr_high_pos = 7;
    localparam int pwr_low_pos = 6;
    localparam int ext_acq_pos = 5;
    localparam int clk_sel_pos = 4;
    localparam int chan_lsb = 0;
    localparam int chan_width = 3;
    localparam logic [7:0] keep_low_mask = 8'h3f;
    localparam logic [7:0] standby_bits = 8'h80;
    localparam logic [7:0] acquire_bits = 8'ha0;
    localparam logic [7:0] full_down_bits = 8'hc0;
    // -------------------------------------------------
    // device bus addresses (byte offsets from base)
    // -------------------------------------------------
    localparam logic [0:0] result_low_addr = 1'h0;
    localparam logic [0:0] result_high_addr = 1'h1;
    localparam int result_width = 16;
    // -------------------------------------------------
    // timing
    // -------------------------------------------------
    localparam int clock_mhz = 20;
    localparam int conv_time_ns = 2000;
    localparam int conv_cycles = (conv_time_ns * clock_mhz + 999) / 1000;
    localparam int ext_clk_div = 4;
    localparam int powerup_us = 100;
    localparam int powerup_cycles = powerup_us * clock_mhz;
    localparam int acq_time_ns = 1000;
    localparam int acq_cycles = (acq_time_ns * clock_mhz + 999) / 1000;
    // -------------------------------------------------
    // host registers over apb (byte addresses)
    // -------------------------------------------------
    localparam logic [7:0] reg_cmd_addr = 8'h00;
    localparam logic [7:0] reg_result_addr = 8'h04;
    localparam logic [7:0] reg_status_addr = 8'h08;
    localparam logic [7:0] reg_irq_addr = 8'h0c;
    localparam logic [7:0] reg_mask_addr = 8'h10;
    localparam logic [7:0] reg_cmd_reset = 8'h00;
    localparam int cmd_mode_lsb = 8;
    localparam int cmd_go_pos = 12;
    localparam int cmd_ref_pos = 13;
    localparam int irq_done_pos = 0;
    localparam int irq_err_pos = 1;
    typedef enum logic [1:0] {seq_standby, seq_full_down, seq_pin_down} seq_mode_type;
endpackage : conv_seq_pkg

// >>> logic/conv_link_if.sv
// Purpose: parallel byte bus plus done and shutdown pins between host and converter
// Assumes: single clock, host is the only bus master
// Notes: data bus split into host write data and device read data with enable
`timescale 1ns/1ps
interface conv_link_if;
    logic cs;
    logic wr;
    logic rd;
    logic addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rdata_oe;
    logic done_n;
    logic shutdown_n;
    modport device (input cs, input wr, input rd, input addr, input wdata, input shutdown_n,
        output rdata, output rdata_oe, output done_n);
    modport host (output cs, output wr, output rd, output addr, output wdata, output shutdown_n,
        input rdata, input rdata_oe, input done_n);
endinterface : conv_link_if

// >>> logic/cycle_timer.sv
// Purpose: loadable down-counter that flags expiry
// Assumes: load may coincide with run; load wins in that cycle
// Notes: shared by both ends for conversion, power-up and acquisition waits
`timescale 1ns/1ps
module cycle_timer #(
    parameter int width = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic load,
    input wire logic [width-1:0] count,
    input wire logic tick,
    output logic expired
);
    typedef struct packed {
        logic [width-1:0] left;
        logic expired;
    } state_type;
    state_type state_reg;
    state_type state_next;
    initial if (width < 2) $error("cycle_timer width too small");
    always_comb
    begin
        state_next = state_reg;
        state_next.expired = 1'b0;
        if (load)
        begin
            state_next.left = count;
        end
        else if (tick && state_reg.left != '0)
        begin
            state_next.left = state_reg.left - 1'b1;
            state_next.expired = (state_reg.left == {{(width-1){1'b0}}, 1'b1});
        end
    end
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    assign expired = state_reg.expired;
endmodule : cycle_timer

// >>> logic/conv_device.sv
// Purpose: converter side: takes control bytes, converts, reports done, serves result
// Assumes: host keeps to the write/read protocol; analog input modelled by a port
// Notes: result is the sampled input word; timing uses internal or divided clock
`timescale 1ns/1ps
module conv_device #(
    parameter int conv_len = conv_seq_pkg::conv_cycles
) (
    input wire logic clock,
    input wire logic srst,
    conv_link_if.device link,
    input wire logic [15:0] analog_word,
    output logic [2:0] power_state,
    output logic internal_clock
);
    typedef enum {dev_off, dev_standby, dev_acquire, dev_convert, dev_full_down} dev_state_type;
    typedef struct packed {
        dev_state_type mode;
        logic int_clk;
        logic end_full;
        logic [15:0] result;
        logic done_n;
        logic [7:0] rdata;
        logic rdata_oe;
        logic [1:0] div;
        logic [2:0] pstate;
    } state_type;
    state_type state_reg;
    state_type state_next;
    logic start;
    logic tick;
    logic conv_done;
    logic write_hit;
    logic [7:0] cw;
    initial if (conv_len < 1 || conv_len > 65535) $error("conv_len out of range");
    assign write_hit = link.cs && link.wr;
    assign cw = link.wdata;
    // -------------------------------------------------
    // conversion timer
    // -------------------------------------------------
    // external clock is slower divided tick
    assign tick = state_reg.int_clk || state_reg.div == 2'h0;
    cycle_timer #(.width(16)) conv_timer (
        .clock(clock),
        .srst(srst),
        .load(start),
        .count(16'(conv_len)),
        .tick(tick),
        .expired(conv_done)
    );
    // -------------------------------------------------
    // sequencing
    // -------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        start = 1'b0;
        state_next.div = state_reg.div + 1'b1;
        if (write_hit)
        begin
            state_next.int_clk = cw[conv_seq_pkg::clk_sel_pos];
        end
        case (state_reg.mode)
            dev_off, dev_standby, dev_full_down, dev_acquire:
            begin
                state_next.mode = state_reg.mode;
            end
            dev_convert:
            begin
                if (conv_done)
                begin
                    state_next.result = analog_word;
                    state_next.done_n = 1'b0;
                    state_next.mode = state_reg.end_full ? dev_full_down : dev_standby;
                end
            end
            default:
            begin
                state_next.mode = dev_off;
            end
        endcase
        // a new control write with power bit seven set, other than an acquire write, restarts, even mid conversion, so power-up writes never swallow the start
        // power bits top two, select bit five
        if (write_hit && cw[conv_seq_pkg::pwr_high_pos])
        begin
            if (cw[conv_seq_pkg::ext_acq_pos] && !cw[conv_seq_pkg::pwr_low_pos])
            begin
                state_next.mode = dev_acquire;
                state_next.done_n = 1'b1;
            end
            else
            begin
                state_next.mode = dev_convert;
                state_next.end_full = cw[conv_seq_pkg::pwr_low_pos];
                state_next.done_n = 1'b1;
                start = 1'b1;
            end
        end
        // pin shutdown wins over everything, aborts a conversion
        if (!link.shutdown_n)
        begin
            state_next.mode = dev_off;
        end
        // low byte at base, high at base plus one
        state_next.rdata_oe = link.cs && link.rd;
        state_next.rdata = (link.addr == conv_seq_pkg::result_high_addr) ? state_reg.result[15:8]
            : state_reg.result[7:0];
        if (link.cs && link.rd && link.addr == conv_seq_pkg::result_high_addr)
        begin
            state_next.done_n = 1'b1;
        end
        case (state_next.mode)
            dev_standby: state_next.pstate = 3'h1;
            dev_acquire: state_next.pstate = 3'h2;
            dev_convert: state_next.pstate = 3'h3;
            dev_full_down: state_next.pstate = 3'h4;
            default: state_next.pstate = 3'h0;
        endcase
    end
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg <= '0;
            state_reg.mode <= dev_standby;
            state_reg.done_n <= 1'b1;
            state_reg.pstate <= 3'h1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    assign link.rdata = state_reg.rdata;
    assign link.rdata_oe = state_reg.rdata_oe;
    assign link.done_n = state_reg.done_n;
    assign power_state = state_reg.pstate;
    assign internal_clock = state_reg.int_clk;
endmodule : conv_device

// >>> logic/conv_host.sv
// Purpose: host sequencer: apb registers drive conversion sequences on the byte bus
// Assumes: apb master never overlaps transfers; converter keeps its protocol
// Notes: pready always high; one write or read strobe cycle per bus access
//
// How it works
// - converter starts on external clock
// - host first switches converter to internal clock
// - select bit cleared unless external acquisition
// - internal reference needs power-up delay
// - standby start converts then stands by
// - done pin low means result readable
// - full-down: standby, delay, then both bits
// - shutdown pin high, delay, convert, pin low
// - select set begins acquisition, cleared converts
// - external full-down start sets both bits
// - result is one sixteen bit word
// - power bits top, select bit five
// - low byte base, high byte base plus one
`timescale 1ns/1ps
module conv_host #(
    parameter int powerup_len = conv_seq_pkg::powerup_cycles,
    parameter int acq_len = conv_seq_pkg::acq_cycles
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    conv_link_if.host link
);
    typedef enum {h_init, h_idle, h_pin_up, h_pwr_wait, h_acq_start, h_acq_wait, h_start,
        h_wait_done, h_read_low, h_read_high, h_finish} host_state_type;
    typedef struct packed {
        host_state_type st;
        logic [7:0] cmd;
        logic [1:0] mode;
        logic ext_acq;
        logic int_ref;
        logic busy;
        logic [15:0] result;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic cs;
        logic wr;
        logic rd;
        logic addr;
        logic [7:0] wdata;
        logic shutdown_n;
        logic [31:0] prdata;
        logic irq;
    } state_type;
    state_type state_reg;
    state_type state_next;
    logic timer_load;
    logic [15:0] timer_count;
    logic timer_done;
    logic wr_acc;
    logic rd_acc;
    logic go;
    logic [1:0] ev;
    logic [7:0] base_byte;
    initial if (powerup_len < 1 || powerup_len > 65535 || acq_len < 1 || acq_len > 65535)
        $error("delay lengths out of range");
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign go = wr_acc && paddr == conv_seq_pkg::reg_cmd_addr && pwdata[conv_seq_pkg::cmd_go_pos];
    assign base_byte = (state_reg.cmd & ~8'(1 << conv_seq_pkg::ext_acq_pos)) | 8'(1 << conv_seq_pkg::clk_sel_pos);
    cycle_timer #(.width(16)) delay_timer (
        .clock(clock),
        .srst(srst),
        .load(timer_load),
        .count(timer_count),
        .tick(1'b1),
        .expired(timer_done)
    );
    always_comb
    begin
        state_next = state_reg;
        timer_load = 1'b0;
        timer_count = 16'(powerup_len);
        ev = 2'h0;
        state_next.cs = 1'b0;
        state_next.wr = 1'b0;
        state_next.rd = 1'b0;
        // -------------------------------------------------
        // apb registers
        // -------------------------------------------------
        if (wr_acc && paddr == conv_seq_pkg::reg_cmd_addr)
        begin
            state_next.cmd = pwdata[7:0] & conv_seq_pkg::keep_low_mask;
            state_next.mode = pwdata[conv_seq_pkg::cmd_mode_lsb +: 2];
            state_next.ext_acq = pwdata[conv_seq_pkg::cmd_mode_lsb + 2];
            state_next.int_ref = pwdata[conv_seq_pkg::cmd_ref_pos];
        end
        if (wr_acc && paddr == conv_seq_pkg::reg_mask_addr)
        begin
            state_next.irq_mask = pwdata[1:0];
        end
        case (paddr)
            conv_seq_pkg::reg_cmd_addr: state_next.prdata = {18'h0, state_reg.int_ref, 2'h0,
                state_reg.ext_acq, state_reg.mode, state_reg.cmd};
            conv_seq_pkg::reg_result_addr: state_next.prdata = {16'h0, state_reg.result};
            conv_seq_pkg::reg_status_addr: state_next.prdata = {30'h0, !link.done_n, state_reg.busy};
            conv_seq_pkg::reg_irq_addr: state_next.prdata = {30'h0, state_reg.irq_status};
            conv_seq_pkg::reg_mask_addr: state_next.prdata = {30'h0, state_reg.irq_mask};
            default: state_next.prdata = 32'h0;
        endcase
        // -------------------------------------------------
        // sequence
        // -------------------------------------------------
        case (state_reg.st)
            h_init:
            begin
                state_next.cs = 1'b1;
                state_next.wr = 1'b1;
                state_next.wdata = 8'h10;
                state_next.shutdown_n = 1'b1;
                state_next.st = h_idle;
            end
            h_idle:
            begin
                // go taken only when idle
                if (go)
                begin
                    state_next.busy = 1'b1;
                    state_next.st = h_pin_up;
                end
            end
            h_pin_up:
            begin
                state_next.shutdown_n = 1'b1;
                if (state_reg.mode == 2'h1)
                begin
                    state_next.cs = 1'b1;
                    state_next.wr = 1'b1;
                    state_next.wdata = base_byte | conv_seq_pkg::standby_bits;
                end
                if (state_reg.int_ref && state_reg.mode != 2'h0)
                begin
                    timer_load = 1'b1;
                    state_next.st = h_pwr_wait;
                end
                else
                begin
                    state_next.st = h_acq_start;
                end
            end
            h_pwr_wait: state_next.st = timer_done ? h_acq_start : h_pwr_wait;
            h_acq_start:
            begin
                if (state_reg.ext_acq)
                begin
                    state_next.cs = 1'b1;
                    state_next.wr = 1'b1;
                    state_next.wdata = base_byte | conv_seq_pkg::acquire_bits;
                    timer_load = 1'b1;
                    timer_count = 16'(acq_len);
                    state_next.st = h_acq_wait;
                end
                else
                begin
                    state_next.st = h_start;
                end
            end
            h_acq_wait: state_next.st = timer_done ? h_start : h_acq_wait;
            h_start:
            begin
                state_next.cs = 1'b1;
                state_next.wr = 1'b1;
                state_next.wdata = base_byte | ((state_reg.mode == 2'h1) ? conv_seq_pkg::full_down_bits
                    : conv_seq_pkg::standby_bits);
                state_next.st = h_wait_done;
            end
            h_wait_done:
            begin
                if (!link.done_n && !state_reg.wr)
                begin
                    state_next.cs = 1'b1;
                    state_next.rd = 1'b1;
                    state_next.addr = conv_seq_pkg::result_low_addr;
                    state_next.st = h_read_low;
                end
            end
            h_read_low:
            begin
                state_next.cs = 1'b1;
                state_next.rd = 1'b1;
                state_next.addr = conv_seq_pkg::result_high_addr;
                state_next.st = h_read_high;
            end
            h_read_high:
            begin
                // read data appears one cycle after each strobe
                state_next.result[7:0] = link.rdata;
                state_next.st = h_finish;
            end
            h_finish:
            begin
                state_next.result[15:8] = link.rdata;
                state_next.busy = 1'b0;
                ev[conv_seq_pkg::irq_done_pos] = 1'b1;
                if (state_reg.mode == 2'h2)
                begin
                    state_next.shutdown_n = 1'b0;
                end
                state_next.st = h_idle;
            end
            default:
            begin
                state_next.st = h_init;
            end
        endcase
        if (state_reg.st != h_idle && go)
        begin
            ev[conv_seq_pkg::irq_err_pos] = 1'b1;
        end
        // set wins over write-one-to-clear
        if (wr_acc && paddr == conv_seq_pkg::reg_irq_addr)
        begin
            state_next.irq_status = state_reg.irq_status & ~pwdata[1:0];
        end
        state_next.irq_status = state_next.irq_status | ev;
        state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    end
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg <= '0;
            state_reg.st <= h_init;
            state_reg.shutdown_n <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    assign prdata = state_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign irq = state_reg.irq;
    assign link.cs = state_reg.cs;
    assign link.wr = state_reg.wr;
    assign link.rd = state_reg.rd;
    assign link.addr = state_reg.addr;
    assign link.wdata = state_reg.wdata;
    assign link.shutdown_n = state_reg.shutdown_n;
endmodule : conv_host

// >>> verif/conv_seq_sva.sv
// Purpose: link checks for the host and converter pair
// Assumes: one clock, sync active-high reset, conv_len 40
// Notes: conversion timing assumes internal clock
`timescale 1ns/1ps
module conv_seq_sva (
    input wire logic clock,
    input wire logic srst,
    input wire logic cs,
    input wire logic wr,
    input wire logic rd,
    input wire logic addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rdata_oe,
    input wire logic done_n,
    input wire logic shutdown_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic [7:0] since_reg;
    logic [7:0] since_next;
    // -------------------------------------------------
    // sequences
    // -------------------------------------------------
    sequence start_wr;
        cs && wr && wdata[7] && !wdata[5];
    endsequence
    sequence acq_wr;
        cs && wr && wdata[7:5] == 3'b101;
    endsequence
    sequence low_rd;
        cs && rd && !addr;
    endsequence
    sequence high_rd;
        cs && rd && addr;
    endsequence
    // saturating count, so a stale start never wraps into range
    always_comb
    begin
        since_next = since_reg;
        if (cs && wr && wdata[7] && !wdata[5])
            since_next = 8'h01;
        else if (since_reg != 8'hff)
            since_next = since_reg + 8'h01;
    end
    always_ff @(posedge clock)
        since_reg <= srst ? 8'hff : since_next;
    // -------------------------------------------------
    // assertions
    // -------------------------------------------------
    chk_clock_select_first:
        assert property ($fell(srst) |-> ##[0:2] (cs && wr && wdata[4])) else $error("no clock select write");
    chk_full_down_select:
        assert property (cs && wr && wdata[7:6] == 2'b11 |-> !wdata[5]) else $error("select set on start");
    chk_start_clears_done:
        assert property (start_wr |-> ##[1:2] done_n) else $error("done low after start");
    chk_conv_time:
        assert property ($fell(done_n) |-> since_reg >= 8'h28 && since_reg <= 8'h2b) else $error("done timing");
    chk_read_after_done:
        assert property (low_rd |-> !done_n) else $error("read before done");
    chk_read_pair_order:
        assert property (low_rd |-> ##[1:4] high_rd) else $error("high byte not read");
    chk_result_driven:
        assert property (cs && rd |=> rdata_oe) else $error("result not driven");
    chk_done_release:
        assert property (high_rd |-> ##[1:2] done_n) else $error("done not released");
    chk_pin_down_quiet:
        assert property (!shutdown_n |-> !cs) else $error("bus used while shut down");
    chk_acquire_start:
        assert property (acq_wr |-> ##[1:40] start_wr) else $error("no start after acquire");
endmodule : conv_seq_sva

// >>> verif/tb_adc_conversion_power_sequencer.sv
// Purpose: drives host registers over apb, converter on the far end
// Assumes: powerup_len 5, acq_len 4 to keep runs short
// Notes: result is the analog word held through each run
`timescale 1ns/1ps
module tb_adc_conversion_power_sequencer;
    logic clock, srst, psel, penable, pwrite, pready, pslverr, irq, internal_clock;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] analog_word;
    logic [2:0] power_state;
    int n_mismatch, total_checks, cycles;
    conv_link_if link();
    conv_host #(.powerup_len(5), .acq_len(4)) u_conv_host (.clock(clock), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .link(link.host));
    conv_device u_conv_device (.clock(clock), .srst(srst), .link(link.device), .analog_word(analog_word),
        .power_state(power_state), .internal_clock(internal_clock));
    conv_seq_sva u_conv_seq_sva (.clock(clock), .srst(srst), .cs(link.cs), .wr(link.wr), .rd(link.rd),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .rdata_oe(link.rdata_oe),
        .done_n(link.done_n), .shutdown_n(link.shutdown_n));
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // polls busy; the cycle ceiling cuts a hang
    task wait_idle;
        do
            apb(1'b0, conv_seq_pkg::reg_status_addr, 32'h0);
        while (rdv[0] !== 1'b0);
    endtask : wait_idle
    task t_reset;
        apb(1'b0, conv_seq_pkg::reg_cmd_addr, 32'h0);
        chk("cmd", 32'h0, rdv);
        apb(1'b0, conv_seq_pkg::reg_irq_addr, 32'h0);
        chk("irq status", 32'h0, rdv);
        chk("internal clock", 32'h1, {31'h0, internal_clock});
        $display("test reset done");
    endtask : t_reset
    task t_conv(input logic [1:0] m, input logic x, input logic [15:0] v);
        analog_word <= v;
        apb(1'b1, conv_seq_pkg::reg_mask_addr, 32'h1);
        apb(1'b1, conv_seq_pkg::reg_cmd_addr, {18'h0, x, 1'b1, 1'b0, x, m, 8'h05});
        wait_idle();
        apb(1'b0, conv_seq_pkg::reg_result_addr, 32'h0);
        chk("result", {16'h0, v}, rdv);
        chk("power", (m == 2'h0) ? 32'h1 : (m == 2'h1) ? 32'h4 : 32'h0, {29'h0, power_state});
        chk("irq pin", 32'h1, {31'h0, irq});
        apb(1'b1, conv_seq_pkg::reg_irq_addr, 32'h1);
        apb(1'b0, conv_seq_pkg::reg_irq_addr, 32'h0);
        chk("irq clear", 32'h0, rdv);
        chk("irq low", 32'h0, {31'h0, irq});
        $display("test conv mode %0d ext %0d done", m, x);
    endtask : t_conv
    task t_refused;
        apb(1'b1, conv_seq_pkg::reg_mask_addr, 32'h3);
        apb(1'b1, conv_seq_pkg::reg_cmd_addr, 32'h1000);
        apb(1'b1, conv_seq_pkg::reg_cmd_addr, 32'h1000);
        apb(1'b0, conv_seq_pkg::reg_irq_addr, 32'h0);
        chk("refused", 32'h2, rdv);
        wait_idle();
        apb(1'b0, conv_seq_pkg::reg_irq_addr, 32'h0);
        chk("both events", 32'h3, rdv);
        apb(1'b1, conv_seq_pkg::reg_mask_addr, 32'h0);
        @(posedge clock);
        chk("masked irq", 32'h0, {31'h0, irq});
        apb(1'b1, conv_seq_pkg::reg_irq_addr, 32'h3);
        $display("test refused done");
    endtask : t_refused
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    initial
    begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        analog_word = 16'h0;
        repeat (16) @(posedge clock);
        chk("external clock", 32'h0, {31'h0, internal_clock});
        srst <= 1'b0;
        t_reset();
        for (int i = 0; i < 6; i++)
            t_conv(2'(i / 2), 1'(i % 2), 16'h1234 + 16'(i * 16'h1111));
        t_refused();
        stop_test();
    end
endmodule : tb_adc_conversion_power_sequencer
